// File: src/error_bank_cfg.svh
// Constants for the machine-check error-reporting bank.
// Assumes inclusion by the bank module only.
`ifndef ERROR_BANK_CFG_SVH
`define ERROR_BANK_CFG_SVH

// ---------------------------------------------------------------
// Record field positions
// ---------------------------------------------------------------
`define REC_ARCH_CODE_LSB   0
`define REC_IMPL_CODE_LSB   16
`define REC_OTHER_LSB       32
`define REC_FW_EDITED       37
`define REC_COUNT_LSB       38
`define REC_COUNT_MSB       52
`define REC_COLOR_LSB       53
`define REC_COLOR_MSB       54
`define REC_ACTION_REQ      55
`define REC_SIGNALLING      56
`define REC_CTX_CORRUPT     57
`define REC_ADDR_VALID      58
`define REC_MISC_VALID      59
`define REC_ENABLED         60
`define REC_UNCORRECTED     61
`define REC_OVERFLOW        62
`define REC_VALID           63

// ---------------------------------------------------------------
// Capability bit positions
// ---------------------------------------------------------------
`define CAP_COUNT_BIT       10
`define CAP_THRESH_BIT      11
`define CAP_RECOVERY_BIT    24
`define CAP_FWFIRST_BIT     25

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MASK_RESET          64'h0000_0000_0000_0000
`define RECORD_RESET        64'h0000_0000_0000_0000

`endif

// File: src/error_bank_pkg.sv
// Types shared by the error-reporting bank.
// Assumes nothing beyond the constants header.
package error_bank_pkg;

    // -----------------------------------------------------------
    // Threshold colour codes
    // -----------------------------------------------------------
    typedef enum logic [1:0]
    {
        COLOR_UNTRACKED = 2'h0,
        COLOR_GREEN     = 2'h1,
        COLOR_YELLOW    = 2'h2,
        COLOR_RESERVED  = 2'h3
    } color_t;

    // -----------------------------------------------------------
    // One error event from a hardware unit
    // -----------------------------------------------------------
    typedef struct packed
    {
        logic [5:0]  errorIndex;
        logic [15:0] archCode;
        logic [15:0] implCode;
        logic [5:0]  otherInfo;
        logic        fwEdited;
        logic        uncorrected;
        logic        monitored;
        color_t      color;
        logic        contextCorrupt;
        logic        actionRequired;
        logic        signalling;
        logic        addrValid;
        logic        miscValid;
    } error_event_t;

    // -----------------------------------------------------------
    // Register access request
    // -----------------------------------------------------------
    typedef enum logic [1:0]
    {
        REG_MASK   = 2'h1,
        REG_RECORD = 2'h2
    } reg_sel_t;

    typedef struct packed
    {
        logic        valid;
        logic        write;
        reg_sel_t    select;
        logic [63:0] data;
    } reg_req_t;

endpackage

// File: src/error_reporting_bank.sv
// One machine-check error-reporting bank: signal-enable mask and error record.
// Assumes events arrive from core-clock logic and register accesses from the
// core's register-access sequencer on the same clock.
//
// How it works
// - Mask holds 64 enable flags; set flag lets its error raise exception.
// - Errors are logged whatever the enable flag says.
// - Writes to unimplemented mask bits are dropped.
// - Record cleared by writing zero; writing any one raises protection fault.
// - Low sixteen bits architectural code, next sixteen implementation code.
// - Firmware-first capability moves other info to 36:32, bit 37 edited.
// - Count capability makes 52:38 a corrected-error counter.
// - Counter top bit is a sticky overflow indicator.
// - With threshold and recovery capabilities bit 56 signalling, bit 55 action required.
// - Corrected errors post threshold colour in bits 54:53.
// - Bit 57 shows processor context may be corrupt.
// - Bit 58 set only when the address register holds the address.
// - Bit 59 set only when the extra-info register holds data.
// - Bit 60 shows the enable flag was set at detection.
// - Bit 61 shows the error was not corrected.
// - Bit 62 set when an error meets a valid record, except on a count-only update; software clears.
// - Enabled beats disabled, uncorrected beats corrected, enabled uncorrected never replaced.
// - With counting, corrected errors that do not replace a valid record only count.
// - Bit 63 set on posting; software clears it.
// - Enabled rank: uncorrected, yellow, then green or untracked.
// - Overwrite takes all second-event data; retention keeps all first.
// - Unmonitored structures post the untracked colour.
`timescale 1ns/1ps
`include "error_bank_cfg.svh"

module error_reporting_bank
    import error_bank_pkg::*;
#(
    parameter logic [63:0] IMPL_MASK = 64'hffff_ffff_ffff_ffff,
    parameter logic [63:0] CAPABILITY = 64'h0000_0000_0300_0c00
)
(
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic         eventValid,
    input  wire error_event_t eventData,
    input  wire reg_req_t     regReq,
    output logic [63:0]       regReadData,
    output logic              regFault,
    output logic              machineCheckRequest,
    output logic [63:0]       bank_signal_enable_mask,
    output logic [63:0]       bank_error_record
);

    initial
    begin
        if (IMPL_MASK == 64'h0)
            $error("IMPL_MASK must provide at least one enable flag");
    end

    // ---------------------------------------------------------------
    // Capability decode
    // ---------------------------------------------------------------
    logic capCount;
    logic capThresh;
    logic capRecovery;
    logic capFwFirst;

    assign capCount    = CAPABILITY[`CAP_COUNT_BIT];
    assign capThresh   = CAPABILITY[`CAP_THRESH_BIT];
    assign capRecovery = CAPABILITY[`CAP_RECOVERY_BIT];
    assign capFwFirst  = CAPABILITY[`CAP_FWFIRST_BIT];

    // Rank of an enabled event: 2 uncorrected, 1 yellow, 0 green or untracked.
    function automatic logic [1:0] rank(input logic uc, input logic [1:0] col);
        if (uc)
            rank = 2'h2;
        else if (col == COLOR_YELLOW)
            rank = 2'h1;
        else
            rank = 2'h0;
    endfunction

    // ---------------------------------------------------------------
    // Event decode
    // ---------------------------------------------------------------
    logic        evEnabled;
    logic [1:0]  evColor;
    logic        recValid;
    logic        recEnabled;
    logic        recUncorr;
    logic        writeMask;
    logic        writeRecord;
    logic        recordClear;
    logic        overwrite;
    logic        countOnly;
    logic [63:0] newRecord;
    logic [14:0] count;
    logic [14:0] next_count;

    assign evEnabled   = bank_signal_enable_mask[eventData.errorIndex];
    // A zero write in the same cycle as an event makes the event a fresh posting.
    assign recValid    = bank_error_record[`REC_VALID] && !recordClear;
    assign recEnabled  = bank_error_record[`REC_ENABLED];
    assign recUncorr   = bank_error_record[`REC_UNCORRECTED];
    assign writeMask   = regReq.valid && regReq.write && regReq.select == REG_MASK;
    assign writeRecord = regReq.valid && regReq.write && regReq.select == REG_RECORD;
    assign recordClear = writeRecord && regReq.data == 64'h0;
    assign count       = bank_error_record[`REC_COUNT_MSB:`REC_COUNT_LSB];

    always_comb
    begin
        // Untracked unless a monitored structure reports a corrected error.
        evColor = COLOR_UNTRACKED;
        if (!eventData.uncorrected && eventData.monitored && capThresh)
            evColor = eventData.color;
    end

    always_comb
    begin
        overwrite = 1'b0;
        if (!recValid)
            overwrite = 1'b1;
        else if (evEnabled != recEnabled)
            overwrite = evEnabled;
        else if (recUncorr)
            overwrite = 1'b0;
        else if (eventData.uncorrected)
            overwrite = 1'b1;
        else if (evEnabled)
            overwrite = rank(1'b0, evColor) > rank(1'b0, bank_error_record[`REC_COLOR_MSB:`REC_COLOR_LSB]);
    end

    // Corrected event that does not overwrite a valid record, with counting present, only counts.
    assign countOnly = recValid && !eventData.uncorrected && capCount && !overwrite;

    always_comb
    begin
        next_count = count;
        if (!eventData.uncorrected && capCount)
        begin
            if (!recValid)
                next_count = 15'h1;
            else if (count[14])
                next_count = {1'b1, 14'(count[13:0] + 14'h1)};
            else
                next_count = 15'(count + 15'h1);
        end
    end

    always_comb
    begin
        newRecord = 64'h0;
        newRecord[15:`REC_ARCH_CODE_LSB]   = eventData.archCode;
        newRecord[31:`REC_IMPL_CODE_LSB]   = eventData.implCode;
        newRecord[37:`REC_OTHER_LSB]       = eventData.otherInfo;
        if (capFwFirst)
            newRecord[`REC_FW_EDITED] = eventData.fwEdited;
        if (capCount)
            newRecord[`REC_COUNT_MSB:`REC_COUNT_LSB] = next_count;
        if (capThresh)
        begin
            newRecord[`REC_COLOR_MSB:`REC_COLOR_LSB] = evColor;
            if (capRecovery)
            begin
                newRecord[`REC_SIGNALLING]  = eventData.signalling;
                newRecord[`REC_ACTION_REQ]  = eventData.actionRequired;
            end
        end
        newRecord[`REC_CTX_CORRUPT] = eventData.contextCorrupt;
        newRecord[`REC_ADDR_VALID]  = eventData.addrValid;
        newRecord[`REC_MISC_VALID]  = eventData.miscValid;
        newRecord[`REC_ENABLED]     = evEnabled;
        newRecord[`REC_UNCORRECTED] = eventData.uncorrected;
        newRecord[`REC_OVERFLOW]    = recValid;
        newRecord[`REC_VALID]       = 1'b1;
    end

    // ---------------------------------------------------------------
    // Signal-enable mask
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            bank_signal_enable_mask <= `MASK_RESET;
        else if (writeMask)
            bank_signal_enable_mask <= (regReq.data & IMPL_MASK) | (bank_signal_enable_mask & ~IMPL_MASK);
    end

    // ---------------------------------------------------------------
    // Error record; events win over a clear in the same cycle
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            bank_error_record <= `RECORD_RESET;
        else if (eventValid)
        begin
            // Logging ignores the enable flag.
            if (recordClear)
                bank_error_record <= {1'b1, 1'b0, newRecord[61:0]};
            else if (overwrite)
                bank_error_record <= newRecord;
            else
            begin
                // Retained record keeps first data; only count and overflow move.
                if (countOnly)
                    bank_error_record[`REC_COUNT_MSB:`REC_COUNT_LSB] <= next_count;
                else
                    bank_error_record[`REC_OVERFLOW] <= 1'b1;
            end
        end
        else if (recordClear)
            bank_error_record <= 64'h0;
    end

    // ---------------------------------------------------------------
    // Register read, fault and exception request
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regReadData <= 64'h0;
            regFault    <= 1'b0;
        end
        else
        begin
            regFault <= writeRecord && !recordClear;
            if (regReq.valid && !regReq.write)
                regReadData <= (regReq.select == REG_MASK) ? bank_signal_enable_mask : bank_error_record;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            machineCheckRequest <= 1'b0;
        else
            machineCheckRequest <= eventValid && evEnabled && eventData.uncorrected;
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence seq_enabled_uc;
        eventValid && evEnabled && eventData.uncorrected;
    endsequence

    mask_signal_a: assert property (seq_enabled_uc |=> machineCheckRequest)
        else $error("enabled uncorrected event did not request exception");
    mask_suppress_a: assert property (eventValid && !evEnabled |=> !machineCheckRequest)
        else $error("disabled event requested exception");
    log_always_a: assert property (eventValid |=> bank_error_record[`REC_VALID])
        else $error("event not logged");
    unimpl_keep_a: assert property (writeMask |=> ((bank_signal_enable_mask ^ $past(bank_signal_enable_mask)) & ~IMPL_MASK) == 64'h0)
        else $error("unimplemented mask bit changed");
    write_fault_a: assert property (writeRecord && regReq.data != 64'h0 |=> regFault)
        else $error("nonzero record write without fault");
    over_set_a: assert property (eventValid && recValid && !countOnly |=> bank_error_record[`REC_OVERFLOW])
        else $error("overflow not set");
    uc_keep_a: assert property (eventValid && recValid && recUncorr && recEnabled && !recordClear |=> $stable(bank_error_record[31:0]))
        else $error("uncorrected record replaced");
    enable_flag_a: assert property (eventValid && !recValid && !recordClear |=> bank_error_record[`REC_ENABLED] == $past(evEnabled))
        else $error("enabled flag mismatch");
    uc_flag_a: assert property (eventValid && overwrite && !recordClear |=> bank_error_record[`REC_UNCORRECTED] == $past(eventData.uncorrected))
        else $error("uncorrected flag mismatch");
    sticky_ovf_a: assert property (bank_error_record[`REC_COUNT_MSB] && capCount && !recordClear && !(eventValid && overwrite) |=> bank_error_record[`REC_COUNT_MSB])
        else $error("counter overflow bit lost");

endmodule

// File: test/error_reporting_bank_bench.sv
// Self-checking bench for the error-reporting bank.
// Assumes the bank package and constants header are compiled before it.
`timescale 1ns/1ps
module error_reporting_bank_bench;
    import error_bank_pkg::*;

    localparam logic [63:0] IMPL = 64'h00ff_ffff_ffff_ffff;
    typedef struct {error_event_t ev; logic en; logic mcr;} row_t;
    typedef struct {int a; int b; logic second; logic over;} pair_t;

    logic         mclk = 1'b0;
    logic         reset_n = 1'b0;
    logic         eventValid = 1'b0;
    error_event_t eventData = '0;
    reg_req_t     regReq = '0;
    logic [63:0]  regReadData;
    logic [63:0]  mask;
    logic [63:0]  rec;
    logic [63:0]  rd;
    logic         regFault;
    logic         mcReq;
    logic         flt;
    logic         mcrSeen;
    int           n_mismatch = 0;
    int           checks = 0;
    int           w;
    row_t         rows[7];
    pair_t        pairs[6];

    error_reporting_bank #(.IMPL_MASK(IMPL)) u_error_reporting_bank (.mclk(mclk), .reset_n(reset_n),
        .eventValid(eventValid), .eventData(eventData), .regReq(regReq), .regReadData(regReadData),
        .regFault(regFault), .machineCheckRequest(mcReq), .bank_signal_enable_mask(mask),
        .bank_error_record(rec));

    initial forever #12.5 mclk = ~mclk;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic error_event_t mk(logic [5:0] i, logic u, logic m, color_t c, logic p);
        return '{errorIndex:i, archCode:{10'h2a5, i}, implCode:{10'h1c3, i}, otherInfo:6'h15,
                 fwEdited:i[0], uncorrected:u, monitored:m, color:c, contextCorrupt:p,
                 actionRequired:u & i[0], signalling:u, addrValid:i[1], miscValid:i[2]};
    endfunction

    function automatic logic [63:0] expRec(error_event_t e, logic en, logic [14:0] cnt, logic ov);
        return {1'b1, ov, e.uncorrected, en, e.miscValid, e.addrValid, e.contextCorrupt, e.signalling,
                e.actionRequired, e.monitored ? e.color : COLOR_UNTRACKED, cnt, e.fwEdited,
                e.otherInfo[4:0], e.implCode, e.archCode};
    endfunction

    // Colour and count are undefined for uncorrected records; overflow is masked where optional.
    function automatic logic [63:0] cmask(logic u, logic chkOver);
        return ~((u ? 64'h007f_ffc0_0000_0000 : 64'h0) | (chkOver ? 64'h0 : 64'h4000_0000_0000_0000));
    endfunction

    task automatic cmp64(string n, logic [63:0] e, logic [63:0] g, logic [63:0] m = '1);
        checks++;
        if ((g & m) !== (e & m))
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e & m, g & m);
        end
    endtask

    task automatic cmp1(string n, logic e, logic g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic regOp(logic wr, reg_sel_t s, logic [63:0] d);
        regReq = '{1'b1, wr, s, d};
        @(negedge mclk);
        rd = regReadData;
        flt = regFault;
        regReq = '0;
        @(negedge mclk);
    endtask

    task automatic send(error_event_t e, int n);
        eventData = e;
        eventValid = 1'b1;
        repeat (n) @(negedge mclk);
        eventValid = 1'b0;
        mcrSeen = mcReq;
        @(negedge mclk);
    endtask

    task automatic sendTwo(error_event_t a, error_event_t b);
        eventData = a;
        eventValid = 1'b1;
        @(negedge mclk);
        eventData = b;
        @(negedge mclk);
        eventValid = 1'b0;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        rows = '{'{mk(6'h4, 0, 1, COLOR_GREEN, 0), 1, 0}, '{mk(6'h1, 0, 1, COLOR_YELLOW, 0), 0, 0},
                 '{mk(6'h5, 1, 0, COLOR_UNTRACKED, 1), 1, 1}, '{mk(6'h2, 1, 0, COLOR_UNTRACKED, 1), 0, 0},
                 '{mk(6'h6, 0, 0, COLOR_YELLOW, 0), 1, 0}, '{mk(6'h7, 0, 1, COLOR_YELLOW, 0), 1, 0},
                 '{mk(6'h4, 1, 1, COLOR_GREEN, 0), 1, 1}};
        pairs = '{'{0, 5, 1, 0}, '{5, 0, 0, 0}, '{0, 2, 1, 1}, '{2, 0, 0, 0}, '{2, 6, 0, 1}, '{1, 0, 1, 0}};
        repeat (8) @(negedge mclk);
        cmp64("maskReset", 64'h0, mask);
        cmp64("recordReset", 64'h0, rec);
        cmp1("faultReset", 1'b0, regFault);
        cmp64("readReset", 64'h0, regReadData);
        cmp1("requestReset", 1'b0, mcReq);
        reset_n = 1'b1;
        @(negedge mclk);
        $display("reset test done");
        regOp(1'b1, REG_MASK, '1);
        regOp(1'b0, REG_MASK, 64'h0);
        cmp64("maskRead", IMPL, rd);
        regOp(1'b1, REG_MASK, 64'h0000_0000_0000_00f0);
        cmp64("maskPort", 64'h0000_0000_0000_00f0, mask);
        foreach (rows[i])
        begin
            regOp(1'b1, REG_RECORD, 64'h0);
            send(rows[i].ev, 1);
            cmp1("machineCheckRequest", rows[i].mcr, mcrSeen);
            cmp1("requestEnd", 1'b0, mcReq);
            cmp64("record", expRec(rows[i].ev, rows[i].en, 15'h1, 1'b0), rec,
                  cmask(rows[i].ev.uncorrected, 1'b1));
        end
        $display("event table test done");
        regOp(1'b1, REG_RECORD, 64'h0000_0000_0000_0001);
        cmp1("writeFault", 1'b1, flt);
        cmp64("recordKept", expRec(rows[6].ev, 1'b1, 15'h1, 1'b0), rec, cmask(1'b1, 1'b1));
        regOp(1'b0, REG_RECORD, 64'h0);
        cmp64("recordRead", expRec(rows[6].ev, 1'b1, 15'h1, 1'b0), rd, cmask(1'b1, 1'b1));
        regOp(1'b1, REG_RECORD, 64'h0);
        cmp1("clearFault", 1'b0, flt);
        cmp64("recordCleared", 64'h0, rec);
        $display("register test done");
        foreach (pairs[i])
        begin
            regOp(1'b1, REG_RECORD, 64'h0);
            sendTwo(rows[pairs[i].a].ev, rows[pairs[i].b].ev);
            w = pairs[i].second ? pairs[i].b : pairs[i].a;
            cmp64("overwrite", expRec(rows[w].ev, rows[w].en, 15'h2, 1'b1), rec,
                  cmask(rows[w].ev.uncorrected, pairs[i].over));
        end
        $display("overwrite test done");
        regOp(1'b1, REG_RECORD, 64'h0);
        send(rows[0].ev, 16384);
        cmp64("countTop", expRec(rows[0].ev, 1'b1, 15'h4000, 1'b0), rec, cmask(1'b0, 1'b0));
        send(rows[0].ev, 16384);
        cmp64("countSticky", expRec(rows[0].ev, 1'b1, 15'h4000, 1'b0), rec, cmask(1'b0, 1'b0));
        $display("counter test done");
        regReq = '{1'b1, 1'b1, REG_RECORD, 64'h0};
        eventData = rows[0].ev;
        eventValid = 1'b1;
        @(negedge mclk);
        regReq = '0;
        eventValid = 1'b0;
        cmp1("raceFault", 1'b0, regFault);
        cmp64("clearRace", expRec(rows[0].ev, 1'b1, 15'h1, 1'b0), rec);
        @(negedge mclk);
        $display("clear race test done");
        final_report();
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        final_report();
    end
endmodule
